// [bench/fcc_cmd_props.sv]
// Port checker for the command block
`timescale 1ns/1ps
module fcc_cmd_props (
  input wire logic              core_clk_i,       // Clock
  input wire logic              reset_i,          // Hard reset
  input wire logic              soft_reset_i,     // Soft reset
  input wire logic              lock_i,           // Lock state
  input wire logic              res_valid_o,      // Result held
  input wire logic              res_ready_i,      // Result read
  input wire logic [7:0]        res_data_o,       // Result byte
  input wire logic [7:0]        main_state_reg_o, // Phase
  input wire fcc_pkg::fcc_cfg_t cfg_o,            // Settings
  input wire logic              fifo_enable_o,    // FIFO on
  input wire logic              implied_seek_o,   // Seek forced
  input wire logic              irq_o,            // Interrupt
  input wire logic              irq_ack_i         // Ack
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  // Settings; soft reset exempts held state, so it is excluded where it flushes
  chk_fifo_sense: assert property (fifo_enable_o == !cfg_o.fifo_disable)
    else $error("fifo enable disagrees with setting");
  chk_seek_forced: assert property (cfg_o.implied_seek_enable |-> implied_seek_o)
    else $error("implied seek not forced");
  chk_hw_default: assert property (disable iff (1'b0) reset_i |-> cfg_o == 15'h2000)
    else $error("settings not default in reset");
  chk_soft_locked: assert property (soft_reset_i && lock_i |=>
    $stable(cfg_o.fifo_disable) && $stable(cfg_o[11:0])) else $error("locked settings lost");
  chk_soft_unlock: assert property (soft_reset_i && !lock_i |=> cfg_o == 15'h2000)
    else $error("unlocked settings not restored");
  chk_res_hold: assert property (res_valid_o && !res_ready_i && !soft_reset_i |=>
    res_valid_o && $stable(res_data_o)) else $error("result byte lost");
  chk_msr_result: assert property ($rose(res_valid_o) |->
    ##[0:1] main_state_reg_o[7:6] == 2'b11) else $error("result phase not shown");
  chk_irq_holds: assert property (irq_o && !irq_ack_i && !soft_reset_i |=> irq_o)
    else $error("interrupt dropped without ack");
  cov_invalid: cover property (res_valid_o && res_data_o == 8'h80);
  cov_irq: cover property ($rose(irq_o));
  cov_locked: cover property (soft_reset_i && lock_i);
endmodule
bind fcc_cmd fcc_cmd_props u_fcc_cmd_props (.*);

// [bench/fcc_cmd_tb.sv]
// Testbench for the command block
`timescale 1ns/1ps
module testbench;
  import fcc_pkg::*;
  logic core_clk_i, reset_i, soft_reset_i, lock_i, rw_done_i, irq_ack_i, index_i, disk_ready_i;
  logic cmd_valid_i, cmd_ready_o, res_valid_o, res_ready_i, implied_seek_o, fifo_enable_o;
  logic irq_o, ready_sense_pend_o, write_gate_o, disk_valid_o;
  logic [7:0] cmd_data_i, res_data_o, main_state_reg_o, pa, d;
  logic [3:0][7:0] present_track_value_i = {8'h04, 8'h03, 8'h02, 8'h01};
  fcc_cfg_t cfg_o;
  fcc_disk_t disk_byte_o;
  int error_cnt, samples_checked, nfil;
  // Short poll window keeps the run brief
  fcc_cmd #(.POLL_WIN_CYC(50)) u_fcc_cmd (.*, .dma_mode_i(1'b0), .perp_bits_i(pa[6:0]),
    .spec_a_i(pa), .spec_b_i(~pa), .last_sector_number_i(pa + 8'h01), .index_field_omit_i(1'b0),
    .write_gate_format_sel_i(2'h0), .mode_seek_en_i(1'b1), .per_command_seek_flag_i(lock_i));
  fcc_host_model u_host (.clk_i(core_clk_i), .valid_o(cmd_valid_i), .data_o(cmd_data_i),
    .ready_i(cmd_ready_o), .rvld_i(res_valid_o), .rdat_i(res_data_o), .rrdy_o(res_ready_i));
  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  // Serializer stalls every other cycle; filler bytes are counted
  always @(negedge core_clk_i) disk_ready_i <= ~disk_ready_i;
  always @(posedge core_clk_i) if (disk_valid_o && disk_ready_i && disk_byte_o === 10'h0e5) nfil++;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask
  task automatic pulse(ref logic s, input int n);
    s = 1'b1;
    wt(n);
    s = 1'b0;
  endtask
  task automatic put(input logic [7:0] q[$]);
    foreach (q[i]) u_host.send(q[i]);
  endtask
  task automatic t_cfg();
    put('{OP_CFG, 8'h00, 8'h5f, 8'hff});
    wt(2);
    chk(cfg_o, 16'h5fff);
    chk(implied_seek_o, 1'b1);
    wt(60);
    chk({irq_o, ready_sense_pend_o}, 2'b00);
    $display("configure test finished");
  endtask
  task automatic t_dump(input logic [7:0] six);
    logic [7:0] e[10] = '{8'h01, 8'h02, 8'h03, 8'h04, pa, six, ~pa, {lock_i, pa[6:0]},
      8'h5f, 8'hff};
    u_host.send(OP_DUMP);
    wt(8);
    chk(cmd_ready_o, 1'b0);
    foreach (e[i]) begin
      u_host.recv(d);
      chk(d, e[i]);
    end
    wt(3);
    chk(res_valid_o, 1'b0);
    $display("dump test finished");
  endtask
  task automatic t_inv();
    logic [7:0] ops[3] = '{8'h00, 8'h12, 8'hff};
    foreach (ops[i]) begin
      u_host.send(ops[i]);
      wt(3);
      chk(main_state_reg_o[7:6], 2'b11);
      u_host.recv(d);
      chk({irq_o, d}, {1'b0, ST0_INV});
    end
    $display("invalid test finished");
  endtask
  task automatic t_fmt();
    put('{8'h4d, 8'h05, 8'h00, 8'h01, 8'h02, 8'he5});
    wt(10);
    chk(write_gate_o, 1'b0);
    pulse(index_i, 4);
    wt(6);
    chk(write_gate_o, 1'b1);
    put('{8'h01, 8'h01, 8'h01, 8'h00});
    for (int i = 0; i < 3000 && nfil < 128; i++) wt(1);
    wt(40);
    chk(nfil[15:0], 16'd128);
    pulse(index_i, 4);
    wt(6);
    chk({irq_o, write_gate_o}, 2'b10);
    for (int i = 0; i < 7; i++) begin
      u_host.recv(d);
      if (i < 3) chk(d, (i == 0) ? 8'h05 : 8'h00);
    end
    pulse(irq_ack_i, 1);
    $display("format test finished");
  endtask
  task automatic t_soft();
    lock_i = 1'b1;
    pulse(soft_reset_i, 1);
    chk({fifo_enable_o, cfg_o}, 16'h8fff);
    chk(implied_seek_o, 1'b1);
    wt(60);
    chk({irq_o, ready_sense_pend_o}, 2'b11);
    pulse(irq_ack_i, 1);
    lock_i = 1'b0;
    pulse(soft_reset_i, 1);
    chk({implied_seek_o, cfg_o}, 16'h2000);
    $display("soft reset test finished");
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    {reset_i, soft_reset_i, lock_i, rw_done_i, irq_ack_i, index_i, disk_ready_i} = 7'h40;
    pa = 8'h35;
    wt(5);
    reset_i = 1'b0;
    t_cfg();
    pulse(rw_done_i, 1);
    t_dump(pa + 8'h01);
    t_inv();
    t_fmt();
    t_dump(8'h01);
    t_soft();
    give_verdict();
  end
  // Tests need some 1000 cycles; 100 us leaves ample margin
  initial begin
    #100000;
    error_cnt++;
    give_verdict();
  end
endmodule

// [bench/fcc_host_model.sv]
// Host model: writes command bytes and reads result bytes
`timescale 1ns/1ps
module fcc_host_model (
  input  wire logic       clk_i,   // Core clock
  output logic            valid_o, // Byte offered
  output logic [7:0]      data_o,  // Command byte
  input  wire logic       ready_i, // Byte taken
  input  wire logic       rvld_i,  // Result waiting
  input  wire logic [7:0] rdat_i,  // Result byte
  output logic            rrdy_o   // Reading result
);
  // Idle at time zero
  initial begin
    valid_o = 1'b0;
    data_o = 8'h00;
    rrdy_o = 1'b0;
  end
  // Byte held until taken; released data shows its inverse, never a stale copy
  task automatic send(input logic [7:0] b);
    @(negedge clk_i);
    valid_o = 1'b1;
    data_o = b;
    do @(posedge clk_i); while (ready_i !== 1'b1);
    @(negedge clk_i);
    valid_o = 1'b0;
    data_o = ~b;
  endtask
  // Result bytes are taken one by one, in order
  task automatic recv(output logic [7:0] d);
    @(negedge clk_i);
    rrdy_o = 1'b1;
    while (rvld_i !== 1'b1) @(negedge clk_i);
    d = rdat_i;
    @(negedge clk_i);
    rrdy_o = 1'b0;
  endtask
endmodule

// [design/fcc_cmd.sv]
// Configure, dump, format track and invalid opcode command processor
// Summary of operation
// - Implied-seek setting 1 forces seek before every read, write, scan, verify.
// - Implied-seek setting 0 leaves seeks to the mode command's per-command flag.
// - FIFO setting 0 enables FIFO for reads and writes; 1 disables; default off.
// - Soft reset restores FIFO setting only while unlocked.
// - Drive-scan disable 0 means polling and an interrupt after each reset.
// - Drive-scan disable set within 500 us of reset suppresses that interrupt.
// - FIFO threshold 00..0F, cleared by soft reset only when unlocked.
// - Precomp start track 00..FF, cleared by soft reset only when unlocked.
// - Hardware reset restores every setting whatever the lock state.
// - Dump is one opcode byte, then ten result bytes read in order.
// - Dump reports each drive's present track low byte.
// - Sixth dump byte: sectors per track after format, else last end-of-track.
// - Eighth dump byte: lock state plus perpendicular mode bits.
// - Last two dump bytes: configure values.
// - Format waits for index, then writes gaps, marks, fields over whole track.
// - Layout follows encoding, index omit, perpendicular, size, count, filler.
// - Format ends at second index with interrupt; three status bytes meaningful.
// - Format gap byte sets length of gap after each data field.
// - Illegal opcode goes straight to result, no interrupt, status bit 7 set.
// - Illegal opcode result status zero is 80 hex.
// - Locked soft reset keeps FIFO enable, threshold and precomp track.
`timescale 1ns/1ps
module fcc_cmd #(
  parameter int POLL_WIN_CYC = fcc_pkg::POLL_WIN_CYC
) (
  input  wire logic             core_clk_i,    // Core clock, 200 MHz
  input  wire logic             reset_i,       // Hardware reset, async high
  input  wire logic             soft_reset_i,  // Software reset pulse
  input  wire logic             cmd_valid_i,   // Host byte offered
  input  wire logic [7:0]       cmd_data_i,    // Host command or format byte
  output logic                  cmd_ready_o,   // Byte accepted
  output logic                  res_valid_o,   // Result byte waiting
  output logic [7:0]            res_data_o,    // Result byte
  input  wire logic             res_ready_i,   // Host reads result
  output logic [7:0]            main_state_reg_o, // Phase status
  input  wire logic             dma_mode_i,    // Transfers by DMA
  input  wire logic             lock_i,        // Lock state
  input  wire logic [6:0]       perp_bits_i,   // Perpendicular mode bits
  input  wire logic [7:0]       spec_a_i,      // Step rate and unload
  input  wire logic [7:0]       spec_b_i,      // Load time and DMA
  input  wire logic [3:0][7:0]  present_track_value_i, // Per drive track
  input  wire logic             rw_done_i,     // Read or write ran
  input  wire logic [7:0]       last_sector_number_i, // Its end of track
  input  wire logic             index_field_omit_i, // Omit index field
  input  wire logic [1:0]       write_gate_format_sel_i, // Perp format
  input  wire logic             mode_seek_en_i, // Mode allows seek flag
  input  wire logic             per_command_seek_flag_i, // Flag in command
  output logic                  implied_seek_o, // Seek before transfer
  output fcc_pkg::fcc_cfg_t     cfg_o,         // Configure settings
  output logic                  fifo_enable_o, // FIFO in use
  output logic                  irq_o,         // Interrupt level
  input  wire logic             irq_ack_i,     // Sense interrupt clears
  output logic                  ready_sense_pend_o, // Four senses owed
  input  wire logic             index_i,       // Index pin, async
  output logic                  write_gate_o,  // Track being written
  output logic                  disk_valid_o,  // Track byte offered
  output fcc_pkg::fcc_disk_t    disk_byte_o,   // Track byte
  input  wire logic             disk_ready_i   // Serializer takes byte
);
  import fcc_pkg::*;

  fcc_state_t state_reg;
  fcc_op_t    op_reg;
  fcc_seg_t   seg_reg;
  fcc_seg_t   seg_next;
  fcc_cfg_t   cfg_reg;
  logic [7:0] pbuf_reg [5];
  logic [2:0] pcnt_reg;
  logic [3:0] ridx_reg;
  logic [3:0] rlast;
  logic       mfm_reg;
  logic       fmt_recent_reg;
  logic [7:0] fmt_sc_reg;
  logic [15:0] cnt_reg;
  logic [7:0] sec_reg;
  logic       idx_s1_reg;
  logic       idx_s2_reg;
  logic       idx_s3_reg;
  logic       idx_rise;
  logic [16:0] win_cnt_reg;
  logic       win_act_reg;
  logic       cmd_take;
  logic       push_valid;
  logic       push_ready;
  logic [7:0] push_data;
  logic       emit_ok;
  logic       go;
  logic       seg_last;
  logic [15:0] seg_len;
  fcc_disk_t  emit;
  logic       cfg_apply;
  logic       fmt_end;
  logic       poll_irq;

  // Index pin passes two flops; third only for edge detect
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      idx_s1_reg <= 1'b0;
      idx_s2_reg <= 1'b0;
      idx_s3_reg <= 1'b0;
    end else begin
      idx_s1_reg <= index_i;
      idx_s2_reg <= idx_s1_reg;
      idx_s3_reg <= idx_s2_reg;
    end
  end
  assign idx_rise = idx_s2_reg & ~idx_s3_reg;

  // Host byte acceptance per phase
  assign emit_ok = ~disk_valid_o | disk_ready_i;
  always_comb begin
    case (state_reg)
      ST_IDLE:  cmd_ready_o = ~res_valid_o;
      ST_PARAM: cmd_ready_o = 1'b1;
      ST_WRITE: cmd_ready_o = (seg_reg == SG_ID) & emit_ok;
      default:  cmd_ready_o = 1'b0;
    endcase
  end
  assign cmd_take  = cmd_valid_i & cmd_ready_o;
  assign cfg_apply = cmd_take & (state_reg == ST_PARAM) & (op_reg == OPK_CFG) &
                     (pcnt_reg == CFG_LAST);
  assign fmt_end   = (state_reg == ST_WRITE) & idx_rise;

  // Result length by command
  always_comb begin
    case (op_reg)
      OPK_DUMP: rlast = DUMP_LAST;
      OPK_FMT:  rlast = FMT_RLAST;
      default:  rlast = INV_LAST;
    endcase
  end

  // Command phase sequencer
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= ST_IDLE;
      op_reg    <= OPK_INV;
      pcnt_reg  <= 3'h0;
      ridx_reg  <= 4'h0;
      mfm_reg   <= 1'b0;
    end else if (soft_reset_i) begin
      state_reg <= ST_IDLE;
      pcnt_reg  <= 3'h0;
      ridx_reg  <= 4'h0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          pcnt_reg <= 3'h0;
          ridx_reg <= 4'h0;
          if (cmd_take) begin
            if (cmd_data_i == OP_CFG) begin
              op_reg    <= OPK_CFG;
              state_reg <= ST_PARAM;
            end else if (cmd_data_i == OP_DUMP) begin
              op_reg    <= OPK_DUMP;
              state_reg <= ST_RESULT;
            end else if (cmd_data_i[4:0] == OP_FMT) begin
              op_reg    <= OPK_FMT;
              mfm_reg   <= cmd_data_i[OP_MFM_B];
              state_reg <= ST_PARAM;
            end else begin
              op_reg    <= OPK_INV;
              state_reg <= ST_RESULT;
            end
          end
        end
        ST_PARAM: begin
          if (cmd_take) begin
            pcnt_reg <= pcnt_reg + 3'h1;
            if (op_reg == OPK_CFG && pcnt_reg == CFG_LAST) begin
              state_reg <= ST_IDLE;
            end else if (op_reg == OPK_FMT && pcnt_reg == FMT_LAST) begin
              state_reg <= ST_EXEC;
            end
          end
        end
        ST_EXEC: begin
          if (idx_rise) state_reg <= ST_WRITE;
        end
        ST_WRITE: begin
          if (idx_rise) state_reg <= ST_RESULT;
        end
        ST_RESULT: begin
          if (push_ready) begin
            ridx_reg <= ridx_reg + 4'h1;
            if (ridx_reg == rlast) state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Parameter bytes, slot 0 is the byte after the opcode
  always_ff @(posedge core_clk_i) begin
    if (cmd_take && state_reg == ST_PARAM) begin
      pbuf_reg[pcnt_reg] <= cmd_data_i;
    end
  end

  // Configure settings; soft reset keeps locked ones
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cfg_reg <= '{EIS_DEF, FDIS_DEF, POLL_DEF, THR_DEF, PRE_DEF};
    end else if (soft_reset_i) begin
      cfg_reg.implied_seek_enable <= EIS_DEF;
      cfg_reg.poll_disable        <= POLL_DEF;
      if (!lock_i) begin
        cfg_reg.fifo_disable        <= FDIS_DEF;
        cfg_reg.fifo_level_setting  <= THR_DEF;
        cfg_reg.precomp_start_track <= PRE_DEF;
      end
    end else if (cfg_apply) begin
      cfg_reg.implied_seek_enable <= pbuf_reg[1][6];
      cfg_reg.fifo_disable        <= pbuf_reg[1][5];
      cfg_reg.poll_disable        <= pbuf_reg[1][4];
      cfg_reg.fifo_level_setting  <= pbuf_reg[1][3:0];
      cfg_reg.precomp_start_track <= cmd_data_i;
    end
  end
  assign cfg_o         = cfg_reg;
  assign fifo_enable_o = ~cfg_reg.fifo_disable;
  // Forced seek overrides the per-command flag
  assign implied_seek_o = cfg_reg.implied_seek_enable |
                          (mode_seek_en_i & per_command_seek_flag_i);

  // Post-reset window; polling interrupt raised when it closes
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      win_cnt_reg <= 17'h0;
      win_act_reg <= 1'b1;
    end else if (soft_reset_i) begin
      win_cnt_reg <= 17'h0;
      win_act_reg <= 1'b1;
    end else if (win_act_reg) begin
      win_cnt_reg <= win_cnt_reg + 17'h1;
      if (win_cnt_reg == 17'(POLL_WIN_CYC - 1)) win_act_reg <= 1'b0;
    end
  end
  // Late configure cannot recall an interrupt already raised
  assign poll_irq = win_act_reg & (win_cnt_reg == 17'(POLL_WIN_CYC - 1)) &
                    ~cfg_reg.poll_disable;

  // Interrupt level; a new event beats the acknowledge
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      irq_o              <= 1'b0;
      ready_sense_pend_o <= 1'b0;
    end else if (soft_reset_i) begin
      irq_o              <= 1'b0;
      ready_sense_pend_o <= 1'b0;
    end else begin
      if (poll_irq || fmt_end) begin
        irq_o <= 1'b1;
      end else if (irq_ack_i) begin
        irq_o <= 1'b0;
      end
      if (poll_irq) begin
        ready_sense_pend_o <= 1'b1;
      end else if (irq_ack_i) begin
        ready_sense_pend_o <= 1'b0;
      end
    end
  end

  // Sixth dump byte source tracks the later of format and transfer
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      fmt_recent_reg <= 1'b0;
      fmt_sc_reg     <= ZERO_B;
    end else if (soft_reset_i) begin
      fmt_recent_reg <= 1'b0;
    end else if (state_reg == ST_EXEC && idx_rise) begin
      fmt_recent_reg <= 1'b1;
      fmt_sc_reg     <= pbuf_reg[2];
    end else if (rw_done_i) begin
      fmt_recent_reg <= 1'b0;
    end
  end

  // Result byte for the current index
  always_comb begin
    push_data = ZERO_B;
    case (op_reg)
      OPK_DUMP: begin
        if (ridx_reg < 4'h4) begin
          push_data = present_track_value_i[ridx_reg[1:0]];
        end else if (ridx_reg == 4'h4) begin
          push_data = spec_a_i;
        end else if (ridx_reg == 4'h5) begin
          push_data = fmt_recent_reg ? fmt_sc_reg
                                     : last_sector_number_i;
        end else if (ridx_reg == 4'h6) begin
          push_data = spec_b_i;
        end else if (ridx_reg == 4'h7) begin
          push_data = {lock_i, perp_bits_i};
        end else if (ridx_reg == 4'h8) begin
          push_data = {1'b0, cfg_reg.implied_seek_enable, cfg_reg.fifo_disable,
                       cfg_reg.poll_disable, cfg_reg.fifo_level_setting};
        end else begin
          push_data = cfg_reg.precomp_start_track;
        end
      end
      OPK_FMT: begin
        // Status zero carries head and drive, rest left clear
        if (ridx_reg == 4'h0) push_data = {5'h00, pbuf_reg[0][2:0]};
      end
      OPK_INV: push_data = ST0_INV;
      default: push_data = ZERO_B;
    endcase
  end
  assign push_valid = (state_reg == ST_RESULT);

  // Result words pass a two-entry buffer so a slow reader loses none
  fcc_res_buf u_res_buf (
    .core_clk_i  (core_clk_i),
    .reset_i     (reset_i),
    .clear_i     (soft_reset_i),
    .in_valid_i  (push_valid),
    .in_ready_o  (push_ready),
    .in_data_i   (push_data),
    .out_valid_o (res_valid_o),
    .out_ready_i (res_ready_i),
    .out_data_o  (res_data_o)
  );

  // Phase status; invalid result shows request and direction set
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      main_state_reg_o <= ZERO_B;
    end else begin
      main_state_reg_o           <= ZERO_B;
      main_state_reg_o[MSR_RQM]  <= cmd_ready_o | res_valid_o;
      main_state_reg_o[MSR_DIO]  <= (state_reg == ST_RESULT) | res_valid_o;
      main_state_reg_o[MSR_NDMA] <= (state_reg == ST_WRITE) & ~dma_mode_i;
      main_state_reg_o[MSR_BUSY] <= (state_reg != ST_IDLE) | res_valid_o;
    end
  end

  // Track writer: byte, length and successor of each segment
  always_comb begin
    emit     = '{1'b0, 1'b0, mfm_reg ? GAP_M : GAP_F};
    seg_len  = 16'hffff;
    seg_next = seg_reg;
    case (seg_reg)
      SG_GAP4A: begin
        seg_len  = mfm_reg ? GAP4A_M : GAP4A_F;
        seg_next = index_field_omit_i ? SG_GAP1 : SG_SYNC_I;
      end
      SG_SYNC_I, SG_SYNC_A, SG_SYNC_D: begin
        emit.val = SYNC_B;
        seg_len  = mfm_reg ? SYNC_M : SYNC_F;
        seg_next = fcc_seg_t'(seg_reg + 4'h1);
      end
      SG_IAM, SG_IDAM, SG_DAM: begin
        emit.mark = 1'b1;
        emit.val  = (seg_reg == SG_IAM) ? IAM_B :
                    (seg_reg == SG_IDAM) ? IDAM_B : DAM_B;
        seg_len   = 16'h0001;
        seg_next  = fcc_seg_t'(seg_reg + 4'h1);
      end
      SG_GAP1: begin
        seg_len  = mfm_reg ? GAP1_M : GAP1_F;
        seg_next = SG_SYNC_A;
      end
      SG_ID: begin
        emit.val = cmd_data_i;
        seg_len  = ID_LEN;
        seg_next = SG_IDCRC;
      end
      SG_IDCRC, SG_DCRC: begin
        emit.crc = 1'b1;
        emit.val = ZERO_B;
        seg_len  = CRC_LEN;
        seg_next = fcc_seg_t'(seg_reg + 4'h1);
      end
      SG_GAP2: begin
        seg_len  = (write_gate_format_sel_i != 2'h0) ? GAP2_P :
                   mfm_reg ? GAP2_M : GAP2_F;
        seg_next = SG_SYNC_D;
      end
      SG_DATA: begin
        emit.val = pbuf_reg[4];
        seg_len  = DATA_BASE << pbuf_reg[1][2:0];
        seg_next = SG_DCRC;
      end
      SG_POST_DATA_GAP: begin
        seg_len  = {8'h00, pbuf_reg[3]};
        seg_next = (sec_reg == pbuf_reg[2] - 8'h1) ? SG_GAP4B : SG_SYNC_A;
      end
      default: begin
        seg_len  = 16'hffff;
        seg_next = SG_GAP4B;
      end
    endcase
  end
  assign seg_last = (cnt_reg == seg_len - 16'h1) & (seg_reg != SG_GAP4B);
  assign go = (state_reg == ST_WRITE) & emit_ok & ~idx_rise &
              ((seg_reg != SG_ID) | cmd_valid_i);

  // Segment and sector counters
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      seg_reg <= SG_GAP4A;
      cnt_reg <= 16'h0;
      sec_reg <= 8'h0;
    end else if (state_reg != ST_WRITE) begin
      seg_reg <= SG_GAP4A;
      cnt_reg <= 16'h0;
      sec_reg <= 8'h0;
    end else if (go) begin
      if (seg_last || seg_len == 16'h0) begin
        cnt_reg <= 16'h0;
        seg_reg <= seg_next;
        if (seg_reg == SG_POST_DATA_GAP) sec_reg <= sec_reg + 8'h1;
      end else if (seg_reg != SG_GAP4B) begin
        cnt_reg <= cnt_reg + 16'h1;
      end
    end
  end

  // Track byte output register
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      disk_valid_o <= 1'b0;
      disk_byte_o  <= '0;
    end else if (soft_reset_i) begin
      disk_valid_o <= 1'b0;
    end else if (go) begin
      disk_valid_o <= 1'b1;
      disk_byte_o  <= emit;
    end else if (disk_ready_i) begin
      disk_valid_o <= 1'b0;
    end
  end
  assign write_gate_o = (state_reg == ST_WRITE);
endmodule

// [design/fcc_pkg.sv]
// Constants and types for the configure, dump, format and invalid command block
package fcc_pkg;
  // Clock and post-reset polling window
  localparam int CLK_MHZ       = 200;
  localparam int POLL_WIN_US   = 500;
  localparam int POLL_WIN_CYC  = POLL_WIN_US * CLK_MHZ;
  // Opcodes handled here
  localparam logic [7:0] OP_CFG    = 8'h13;
  localparam logic [7:0] OP_DUMP   = 8'h0e;
  localparam logic [4:0] OP_FMT    = 5'h0d;
  localparam int         OP_MFM_B  = 6;
  // Byte counts
  localparam logic [2:0] CFG_LAST  = 3'h2;
  localparam logic [2:0] FMT_LAST  = 3'h4;
  localparam logic [3:0] DUMP_LAST = 4'h9;
  localparam logic [3:0] FMT_RLAST = 4'h6;
  localparam logic [3:0] INV_LAST  = 4'h0;
  localparam logic [15:0] ID_LEN   = 16'h0004;
  localparam logic [15:0] CRC_LEN  = 16'h0002;
  localparam logic [15:0] DATA_BASE = 16'h0080;
  // Track layout lengths, MFM then FM
  localparam logic [15:0] GAP4A_M = 16'h0050;
  localparam logic [15:0] GAP4A_F = 16'h0028;
  localparam logic [15:0] SYNC_M  = 16'h000c;
  localparam logic [15:0] SYNC_F  = 16'h0006;
  localparam logic [15:0] GAP1_M  = 16'h0032;
  localparam logic [15:0] GAP1_F  = 16'h001a;
  localparam logic [15:0] GAP2_M  = 16'h0016;
  localparam logic [15:0] GAP2_F  = 16'h000b;
  localparam logic [15:0] GAP2_P  = 16'h0029;
  // Track byte values
  localparam logic [7:0] GAP_M    = 8'h4e;
  localparam logic [7:0] GAP_F    = 8'hff;
  localparam logic [7:0] SYNC_B   = 8'h00;
  localparam logic [7:0] IAM_B    = 8'hfc;
  localparam logic [7:0] IDAM_B   = 8'hfe;
  localparam logic [7:0] DAM_B    = 8'hfb;
  // Result and status values
  localparam logic [7:0] ST0_INV  = 8'h80;
  localparam logic [7:0] ZERO_B   = 8'h00;
  localparam int MSR_RQM  = 7;
  localparam int MSR_DIO  = 6;
  localparam int MSR_NDMA = 5;
  localparam int MSR_BUSY = 4;
  // Configuration defaults
  localparam logic       EIS_DEF  = 1'b0;
  localparam logic       FDIS_DEF = 1'b1;
  localparam logic       POLL_DEF = 1'b0;
  localparam logic [3:0] THR_DEF  = 4'h0;
  localparam logic [7:0] PRE_DEF  = 8'h00;

  typedef struct packed {
    logic       implied_seek_enable;
    logic       fifo_disable;
    logic       poll_disable;
    logic [3:0] fifo_level_setting;
    logic [7:0] precomp_start_track;
  } fcc_cfg_t;

  typedef struct packed {
    logic       mark;
    logic       crc;
    logic [7:0] val;
  } fcc_disk_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_PARAM = 3'b001, ST_EXEC = 3'b011,
    ST_WRITE = 3'b010, ST_RESULT = 3'b110
  } fcc_state_t;

  typedef enum logic [1:0] {
    OPK_CFG = 2'h0, OPK_DUMP = 2'h1, OPK_FMT = 2'h2, OPK_INV = 2'h3
  } fcc_op_t;

  typedef enum logic [3:0] {
    SG_GAP4A = 4'h0, SG_SYNC_I = 4'h1, SG_IAM = 4'h2, SG_GAP1 = 4'h3,
    SG_SYNC_A = 4'h4, SG_IDAM = 4'h5, SG_ID = 4'h6, SG_IDCRC = 4'h7,
    SG_GAP2 = 4'h8, SG_SYNC_D = 4'h9, SG_DAM = 4'ha, SG_DATA = 4'hb,
    SG_DCRC = 4'hc, SG_POST_DATA_GAP = 4'hd, SG_GAP4B = 4'he
  } fcc_seg_t;
endpackage

// [design/fcc_res_buf.sv]
// Two-entry result buffer with valid and ready on both sides
`timescale 1ns/1ps
module fcc_res_buf (
  input  wire logic       core_clk_i, // Core clock
  input  wire logic       reset_i,    // Async reset, high
  input  wire logic       clear_i,    // Soft flush
  input  wire logic       in_valid_i, // Word offered
  output logic            in_ready_o, // Room for a word
  input  wire logic [7:0] in_data_i,  // Word in
  output logic            out_valid_o, // Word held
  input  wire logic       out_ready_i, // Reader takes word
  output logic [7:0]      out_data_o  // Oldest word
);
  logic [7:0] mem_reg [2];
  logic       wp_reg;
  logic       rp_reg;
  logic [1:0] cnt_reg;
  logic       push;
  logic       pop;

  // Full and empty straight from the count
  assign in_ready_o  = (cnt_reg != 2'h2);
  assign out_valid_o = (cnt_reg != 2'h0);
  assign out_data_o  = mem_reg[rp_reg];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // Storage needs no reset, it is only read when counted
  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem_reg[wp_reg] <= in_data_i;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wp_reg  <= 1'b0;
      rp_reg  <= 1'b0;
      cnt_reg <= 2'h0;
    end else if (clear_i) begin
      wp_reg  <= 1'b0;
      rp_reg  <= 1'b0;
      cnt_reg <= 2'h0;
    end else begin
      if (push) wp_reg <= ~wp_reg;
      if (pop) rp_reg <= ~rp_reg;
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule
